// ### rtl/efp_flash_seq.v
`timescale 1ns/1ps
`default_nettype none
`include "efp_regs.vh"
module efp_flash_seq
(
  input  wire        clock,
  input  wire        resetn,
  input  wire [15:0] reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [7:0]  reg_rdata,
  input  wire        two_flash_strap,
  output reg  [27:0] flash_addr,
  output reg  [7:0]  flash_dq_out,
  output reg         flash_dq_oe,
  input  wire [7:0]  flash_dq_in,
  output reg         flash_we_n,
  output reg         flash_oe_n,
  output reg         first_chip_enable_n,
  output reg         second_chip_enable_n
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_SETUP = 3'h1;
  localparam [2:0] ST_PULSE = 3'h2;
  localparam [2:0] ST_GAP   = 3'h3;
  localparam [2:0] ST_POLL  = 3'h4;
  localparam [2:0] ST_READ  = 3'h5;
  localparam [1:0] OP_PROG   = 2'h1;
  localparam [1:0] OP_ERASE  = 2'h2;
  localparam [1:0] OP_VERIFY = 2'h3;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [7:0]  flash_control;
  reg  [7:0]  prog_bank_high;
  reg  [7:0]  prog_bank_low;
  reg  [7:0]  prog_addr_high;
  reg  [7:0]  prog_addr_low;
  reg  [7:0]  prog_data_byte;
  reg  [7:0]  sector_addr_high;
  reg  [7:0]  sector_addr_mid;
  reg  [7:0]  sector_addr_low;
  reg  [7:0]  verify_result;
  reg  [2:0]  state;
  reg  [1:0]  op;
  reg  [2:0]  step;
  reg  [7:0]  timer;
  reg  [23:0] poll_count;
  reg         strap_seen;
  reg         busy;
  reg         fail;

  wire [27:0] target_location;
  wire [27:0] erase_sector_location;
  wire [2:0]  last_step;
  wire        fmt2;
  reg  [11:0] cyc_lo;
  reg  [7:0]  cyc_data;
  reg  [27:0] cyc_addr;

  // Bank picks a 16K window; address 8000h-BFFFh maps into it
  assign target_location = {prog_bank_high[3:0], prog_bank_low,
                            2'b00, prog_addr_high[5:0], prog_addr_low};
  // Sector value is the leading digits of the start address
  assign erase_sector_location = {sector_addr_high[3:0], sector_addr_mid,
                                  sector_addr_low, 8'h00};
  assign fmt2 = flash_control[`EFP_CTL_FMT];
  assign last_step = (op == OP_ERASE) ? 3'd5 : 3'd3;

  // Unlock address per format
  function [11:0] unlock_addr;
    input f2;
    input second;
    begin
      if (f2)
        unlock_addr = second ? `EFP_U2_FMT2 : `EFP_U1_FMT2;
      else
        unlock_addr = second ? `EFP_U2_FMT1 : `EFP_U1_FMT1;
    end
  endfunction

  // ----------------------------------------
  // Bus cycle table
  // ----------------------------------------
  always @*
  begin
    cyc_lo = unlock_addr(fmt2, 1'b0);
    cyc_data = `EFP_D_AA;
    cyc_addr = 28'h0000000;
    case (step)
      3'd1:
      begin
        cyc_lo = unlock_addr(fmt2, 1'b1);
        cyc_data = `EFP_D_55;
      end
      3'd2:
        cyc_data = (op == OP_PROG) ? `EFP_D_A0 : `EFP_D_80;
      3'd3:
        if (op == OP_PROG)
          cyc_data = prog_data_byte;
      3'd4:
      begin
        cyc_lo = unlock_addr(fmt2, 1'b1);
        cyc_data = `EFP_D_55;
      end
      3'd5:
        cyc_data = flash_control[`EFP_CTL_SECTOR] ? `EFP_D_SECT : `EFP_D_CHIP;
      default:
        cyc_data = `EFP_D_AA;
    endcase
    // Upper bits stay zero on unlock cycles; only target cycles carry them
    if (op == OP_PROG && step == 3'd3)
      cyc_addr = target_location;
    else if (op == OP_ERASE && step == 3'd5 && flash_control[`EFP_CTL_SECTOR])
      cyc_addr = erase_sector_location;
    else
      cyc_addr = {16'h0000, cyc_lo};
  end

  // ----------------------------------------
  // Register write, sequencer
  // ----------------------------------------
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      flash_control <= 8'h00;
      prog_bank_high <= 8'h00;
      prog_bank_low <= 8'h00;
      prog_addr_high <= 8'h00;
      prog_addr_low <= 8'h00;
      prog_data_byte <= 8'h00;
      sector_addr_high <= 8'h00;
      sector_addr_mid <= 8'h00;
      sector_addr_low <= 8'h00;
      verify_result <= 8'h00;
      strap_seen <= 1'b0;
      state <= ST_IDLE;
      op <= 2'h0;
      step <= 3'h0;
      timer <= 8'h00;
      poll_count <= 24'h000000;
      busy <= 1'b0;
      fail <= 1'b0;
      flash_addr <= 28'h0000000;
      flash_dq_out <= 8'h00;
      flash_dq_oe <= 1'b0;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
    end
    else
    begin
      // Strap for one or two chips is caught after reset release
      if (!strap_seen)
      begin
        strap_seen <= 1'b1;
        flash_control[`EFP_CTL_TWO] <= two_flash_strap;
      end
      if (reg_write)
      begin
        case (reg_addr)
          `EFP_OFF_CTRL:
            flash_control <= (flash_control & ~`EFP_CTL_WMASK)
                             | (reg_wdata & `EFP_CTL_WMASK);
          `EFP_OFF_BANK_HI:  prog_bank_high <= reg_wdata;
          `EFP_OFF_BANK_LO:  prog_bank_low <= reg_wdata;
          `EFP_OFF_ADDR_HI:  prog_addr_high <= reg_wdata;
          `EFP_OFF_ADDR_LO:  prog_addr_low <= reg_wdata;
          `EFP_OFF_DATA:     prog_data_byte <= reg_wdata;
          `EFP_OFF_SECT_HI:  sector_addr_high <= reg_wdata;
          `EFP_OFF_SECT_MID: sector_addr_mid <= reg_wdata;
          `EFP_OFF_SECT_LO:  sector_addr_low <= reg_wdata;
          `EFP_OFF_CMD:
            if (!busy)
            begin
              busy <= (reg_wdata == `EFP_GO_PROG) || (reg_wdata == `EFP_GO_ERASE)
                      || (reg_wdata == `EFP_GO_VERIFY);
              op <= reg_wdata[1:0];
              step <= 3'h0;
              fail <= 1'b0;
              state <= (reg_wdata == `EFP_GO_VERIFY) ? ST_READ : ST_SETUP;
              if (reg_wdata != `EFP_GO_PROG && reg_wdata != `EFP_GO_ERASE
                  && reg_wdata != `EFP_GO_VERIFY)
                state <= ST_IDLE;
              timer <= 8'h00;
            end
          default:
            flash_control <= flash_control;
        endcase
      end
      case (state)
        ST_IDLE:
        begin
          flash_we_n <= 1'b1;
          flash_oe_n <= 1'b1;
          flash_dq_oe <= 1'b0;
        end
        ST_SETUP:
        begin
          flash_addr <= cyc_addr;
          flash_dq_out <= cyc_data;
          flash_dq_oe <= 1'b1;
          state <= ST_PULSE;
          timer <= 8'h00;
        end
        ST_PULSE:
        begin
          // Each command cycle is one full write strobe
          flash_we_n <= 1'b0;
          timer <= timer + 8'h01;
          if (timer == `EFP_WE_CYC)
          begin
            flash_we_n <= 1'b1;
            state <= ST_GAP;
          end
        end
        ST_GAP:
        begin
          if (step == last_step)
          begin
            flash_dq_oe <= 1'b0;
            poll_count <= 24'h000000;
            state <= ST_POLL;
          end
          else
          begin
            step <= step + 3'h1;
            state <= ST_SETUP;
          end
        end
        ST_POLL:
        begin
          // Data polling: DQ7 reads true data once the flash is done
          flash_oe_n <= 1'b0;
          poll_count <= poll_count + 24'h000001;
          if (!flash_oe_n && (flash_dq_in[`EFP_DQ7] == ((op == OP_PROG) ?
              prog_data_byte[`EFP_DQ7] : 1'b1)) || poll_count == `EFP_POLL_LIMIT)
          begin
            fail <= (poll_count == `EFP_POLL_LIMIT);
            if (op == OP_PROG)
              flash_control[`EFP_CTL_PROG_OK] <= (poll_count != `EFP_POLL_LIMIT);
            else
              flash_control[`EFP_CTL_ERASE_OK] <= (poll_count != `EFP_POLL_LIMIT);
            busy <= 1'b0;
            flash_oe_n <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_READ:
        begin
          flash_addr <= erase_sector_location;
          flash_oe_n <= 1'b0;
          timer <= timer + 8'h01;
          if (timer == `EFP_WE_CYC)
          begin
            if (flash_dq_in == `EFP_D_PROTECTED)
              verify_result <= `EFP_D_PROTECTED;
            else if (flash_dq_in == `EFP_D_UNPROTECTED)
              verify_result <= `EFP_D_UNPROTECTED;
            else
              verify_result <= 8'hff;
            flash_oe_n <= 1'b1;
            busy <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Chip enables
  // ----------------------------------------
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      first_chip_enable_n <= 1'b1;
      second_chip_enable_n <= 1'b1;
    end
    else
    begin
      first_chip_enable_n <= !(busy && !flash_control[`EFP_CTL_CHIP2]);
      second_chip_enable_n <= !(busy && flash_control[`EFP_CTL_CHIP2]);
    end
  end

  // ----------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------
  always @(posedge clock)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_read)
    begin
      case (reg_addr)
        `EFP_OFF_CTRL:     reg_rdata <= flash_control & 8'h3f;
        `EFP_OFF_BANK_HI:  reg_rdata <= prog_bank_high;
        `EFP_OFF_BANK_LO:  reg_rdata <= prog_bank_low;
        `EFP_OFF_ADDR_HI:  reg_rdata <= prog_addr_high;
        `EFP_OFF_ADDR_LO:  reg_rdata <= prog_addr_low;
        `EFP_OFF_DATA:     reg_rdata <= prog_data_byte;
        `EFP_OFF_SECT_HI:  reg_rdata <= sector_addr_high;
        `EFP_OFF_SECT_MID: reg_rdata <= sector_addr_mid;
        `EFP_OFF_SECT_LO:  reg_rdata <= sector_addr_low;
        `EFP_OFF_STAT:     reg_rdata <= {6'h00, fail, busy};
        `EFP_OFF_CMD:      reg_rdata <= verify_result;
        default:           reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

endmodule
`default_nettype wire

// ### rtl/efp_regs.vh
`ifndef EFP_REGS_VH
`define EFP_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define EFP_OFF_CTRL      16'h1050
`define EFP_OFF_BANK_HI   16'h1051
`define EFP_OFF_BANK_LO   16'h1052
`define EFP_OFF_ADDR_HI   16'h1053
`define EFP_OFF_ADDR_LO   16'h1054
`define EFP_OFF_DATA      16'h1055
`define EFP_OFF_SECT_HI   16'h1056
`define EFP_OFF_SECT_MID  16'h1057
`define EFP_OFF_SECT_LO   16'h1058
`define EFP_OFF_CMD       16'h1059
`define EFP_OFF_STAT      16'h105a
// ----------------------------------------
// Control fields
// ----------------------------------------
`define EFP_CTL_FMT       0
`define EFP_CTL_TWO       1
`define EFP_CTL_CHIP2     2
`define EFP_CTL_PROG_OK   3
`define EFP_CTL_SECTOR    4
`define EFP_CTL_ERASE_OK  5
`define EFP_CTL_WMASK     8'h3d
// Command register codes
`define EFP_GO_PROG       8'h01
`define EFP_GO_ERASE      8'h02
`define EFP_GO_VERIFY     8'h03
// ----------------------------------------
// Flash command bytes and unlock addresses
// ----------------------------------------
`define EFP_D_AA          8'haa
`define EFP_D_55          8'h55
`define EFP_D_80          8'h80
`define EFP_D_A0          8'ha0
`define EFP_D_CHIP        8'h10
`define EFP_D_SECT        8'h30
`define EFP_D_PROTECTED   8'h01
`define EFP_D_UNPROTECTED 8'h00
`define EFP_U1_FMT1       12'h555
`define EFP_U2_FMT1       12'h2aa
`define EFP_U1_FMT2       12'haaa
`define EFP_U2_FMT2       12'h555
`define EFP_DQ7           7
// ----------------------------------------
// Timing
// ----------------------------------------
`define EFP_CLK_NS        10
`define EFP_WE_NS         50
`define EFP_WE_CYC        ((`EFP_WE_NS + `EFP_CLK_NS - 1) / `EFP_CLK_NS)
`define EFP_POLL_LIMIT    24'hffffff
`endif

// ### verif/efp_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module efp_flash_model
(
  input  wire logic        clock,
  input  wire logic [27:0] addr,
  input  wire logic [7:0]  dq_out,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        ce1_n,
  input  wire logic        ce2_n,
  output var  logic [7:0]  dq_in
);
  logic [7:0]  rd_val;
  logic [27:0] la [0:7];
  logic [7:0]  ld [0:7];
  logic        lc [0:7];
  int          nwr  = 0;
  int          busy = 0;
  logic        prot = 1'b0;
  logic [7:0]  val  = 8'h00;
  // ----------------------------------------
  // Command cycles latch on the rising strobe
  // ----------------------------------------
  always @(posedge we_n)
    if (!(ce1_n && ce2_n))
    begin
      la[nwr & 7] = addr;
      ld[nwr & 7] = dq_out;
      lc[nwr & 7] = !ce2_n;
      if (nwr == 3 && ld[2] == 8'ha0)
        val = dq_out;
      if (nwr == 5)
        val = 8'hff;
      nwr = nwr + 1;
    end
  // Busy part answers with every bit of the value inverted; the answer follows output enable at once
  assign rd_val = (nwr == 0) ? {7'h00, prot} : ((busy > 0) ? ~val : val);
  // A released bus shows the inverse, so a stale value can never pass as data
  always_comb
    dq_in = (!oe_n && !(ce1_n && ce2_n)) ? rd_val : ~rd_val;
  always @(posedge clock)
    if (!oe_n && !(ce1_n && ce2_n) && busy > 0)
      busy <= busy - 1;
endmodule
`default_nettype wire

// ### verif/efp_flash_seq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module efp_flash_seq_asserts
(
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  input wire logic [27:0] flash_addr,
  input wire logic [7:0]  flash_dq_out,
  input wire logic        flash_dq_oe,
  input wire logic        flash_we_n,
  input wire logic        flash_oe_n,
  input wire logic        first_chip_enable_n,
  input wire logic        second_chip_enable_n
);
  wire sel;
  assign sel = !first_chip_enable_n || !second_chip_enable_n;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // Register port and flash bus cycles
  // ----------------------------------------
  chk_rdata_slot_only: assert property (reg_rdata != 8'h00 |-> $past(reg_read))
    else $error("read data outside its slot");
  chk_one_chip_sel: assert property (!(!first_chip_enable_n && !second_chip_enable_n))
    else $error("both chip enables low");
  chk_we_qualified: assert property (!flash_we_n |-> sel && flash_dq_oe && flash_oe_n)
    else $error("write strobe without select or data");
  chk_we_low_width: assert property ($fell(flash_we_n) |=> !flash_we_n[*4] ##1 flash_we_n)
    else $error("write strobe not five cycles");
  chk_we_gap_high: assert property ($rose(flash_we_n) |=> flash_we_n)
    else $error("no gap after write strobe");
  // Address and data may not move under a low strobe
  chk_cycle_stable: assert property (!flash_we_n ##1 !flash_we_n
    |-> $stable(flash_addr) && $stable(flash_dq_out))
    else $error("address or data moved during strobe");
  chk_we_setup_cyc: assert property ($fell(flash_we_n) |-> $past(sel) && $past(flash_dq_oe))
    else $error("no setup cycle before strobe");
  chk_read_no_drive: assert property (!flash_oe_n |-> !flash_dq_oe && sel && flash_we_n)
    else $error("bus contention on flash read");
endmodule
bind efp_flash_seq efp_flash_seq_asserts efp_flash_seq_asserts_inst
(
  .clock                (clock),
  .resetn               (resetn),
  .reg_read             (reg_read),
  .reg_rdata            (reg_rdata),
  .flash_addr           (flash_addr),
  .flash_dq_out         (flash_dq_out),
  .flash_dq_oe          (flash_dq_oe),
  .flash_we_n           (flash_we_n),
  .flash_oe_n           (flash_oe_n),
  .first_chip_enable_n  (first_chip_enable_n),
  .second_chip_enable_n (second_chip_enable_n)
);
`default_nettype wire

// ### verif/efp_flash_seq_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module efp_flash_seq_tb_top;
  logic        clock     = 1'b0;
  logic        resetn    = 1'b0;
  logic [15:0] reg_addr  = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read  = 1'b0;
  logic        strap     = 1'b0;
  logic [7:0]  v;
  wire  [7:0]  rdata;
  wire  [7:0]  dq_out;
  wire  [7:0]  dq_in;
  wire  [27:0] fa;
  wire         dq_oe;
  wire         we_n;
  wire         oe_n;
  wire         ce1_n;
  wire         ce2_n;
  int          fail_count = 0;
  int          checks     = 0;
  int          i;
  initial forever #5 clock = ~clock;
  efp_flash_seq efp_flash_seq_inst
  (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(rdata),
    .two_flash_strap(strap), .flash_addr(fa), .flash_dq_out(dq_out),
    .flash_dq_oe(dq_oe), .flash_dq_in(dq_in), .flash_we_n(we_n), .flash_oe_n(oe_n),
    .first_chip_enable_n(ce1_n), .second_chip_enable_n(ce2_n)
  );
  efp_flash_model efp_flash_model_inst
  (
    .clock(clock), .addr(fa), .dq_out(dq_out), .we_n(we_n), .oe_n(oe_n),
    .ce1_n(ce1_n), .ce2_n(ce2_n), .dq_in(dq_in)
  );
  // ----------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task rd(input logic [15:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    v = rdata;
  endtask
  task cmp(input logic [27:0] g, input logic [27:0] e);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task rchk(input logic [15:0] a, input logic [7:0] e);
    rd(a);
    cmp(v, e);
  endtask
  // Second command lands while busy and must be dropped
  task run(input logic [7:0] c);
    int n;
    efp_flash_model_inst.nwr = 0;
    wr(16'h1059, c);
    wr(16'h1059, c);
    n = 0;
    v = 8'h01;
    while (v[0] !== 1'b0 && n < 2000)
    begin
      rd(16'h105a);
      n++;
    end
    cmp(v[0], 1'b0);
  endtask
  task chk_seq(input int n, input logic f, input logic [7:0] d2, input logic [7:0] d5);
    int k;
    logic [11:0] u1;
    logic [11:0] u2;
    u1 = f ? 12'haaa : 12'h555;
    u2 = f ? 12'h555 : 12'h2aa;
    cmp(efp_flash_model_inst.nwr, n);
    for (k = 0; k < n; k++)
    begin
      cmp(efp_flash_model_inst.ld[k], (k % 3 == 0 && k != n - 1) ? 8'haa :
          (k % 3 == 1) ? 8'h55 : (k == 2) ? d2 : d5);
      if (!(n == 4 && k == 3) && k != 5)
        cmp(efp_flash_model_inst.la[k][11:0], (k % 3 == 1) ? u2 : u1);
    end
  endtask
  function automatic logic [7:0] pat(input int k);
    return (8'h5a ^ k) & ((k == 6) ? 8'h0f : 8'hff);
  endfunction
  task test_done;
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #500000;
    fail_count++;
    test_done;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    for (i = 0; i < 9; i++)
      rchk(16'h1050 + i, 8'h00);
    for (i = 1; i < 9; i++)
      wr(16'h1050 + i, pat(i));
    for (i = 1; i < 9; i++)
      rchk(16'h1050 + i, pat(i));
    rchk(16'h1070, 8'h00);
    wr(16'h1050, 8'h01);
    wr(16'h1051, 8'h03);
    wr(16'h1052, 8'h07);
    wr(16'h1053, 8'h81);
    wr(16'h1054, 8'h23);
    wr(16'h1055, 8'h66);
    efp_flash_model_inst.busy = 3;
    run(8'h01);
    chk_seq(4, 1'b1, 8'ha0, 8'h66);
    cmp(efp_flash_model_inst.la[3], 28'h3070123);
    cmp(efp_flash_model_inst.lc[3], 1'b0);
    rchk(16'h1050, 8'h09);
    // Window end reached: step to the next bank and restart at 8000h
    wr(16'h1050, 8'h01);
    wr(16'h1052, 8'h08);
    wr(16'h1053, 8'h80);
    wr(16'h1054, 8'h00);
    wr(16'h1055, 8'ha5);
    efp_flash_model_inst.busy = 2;
    run(8'h01);
    chk_seq(4, 1'b1, 8'ha0, 8'ha5);
    cmp(efp_flash_model_inst.la[3], 28'h3080000);
    rchk(16'h1050, 8'h09);
    wr(16'h1050, 8'h04);
    efp_flash_model_inst.busy = 2;
    run(8'h02);
    chk_seq(6, 1'b0, 8'h80, 8'h10);
    cmp(efp_flash_model_inst.lc[5], 1'b1);
    rd(16'h1050);
    cmp(v[5], 1'b1);
    wr(16'h1056, 8'h00);
    wr(16'h1057, 8'h01);
    wr(16'h1058, 8'h50);
    wr(16'h1050, 8'h11);
    run(8'h02);
    chk_seq(6, 1'b1, 8'h80, 8'h30);
    cmp(efp_flash_model_inst.la[5], 28'h0015000);
    rd(16'h1050);
    cmp(v[5], 1'b1);
    efp_flash_model_inst.prot = 1'b1;
    run(8'h03);
    rchk(16'h1059, 8'h01);
    efp_flash_model_inst.prot = 1'b0;
    run(8'h03);
    rchk(16'h1059, 8'h00);
    // Second reset while idle: registers clear and the strap is caught again
    @(posedge clock);
    strap  <= 1'b1;
    resetn <= 1'b0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    rchk(16'h1050, 8'h02);
    rchk(16'h1055, 8'h00);
    wr(16'h1050, 8'h00);
    rchk(16'h1050, 8'h02);
    test_done;
  end
endmodule
`default_nettype wire
